// [include/pmc_pkg.sv]
/*
 Constants shared by the power and mode control logic: control bus
 addresses, bit positions, write masks, mode codes and timing counts.
 Assumes a 100 MHz core clock and writes already decoded from the bus.
*/
// Behaviour
// - Power-on clears core hold and crystal disable.
// - Setting either bit halts all command handling.
// - General reset command still honoured while halted.
// - Core hold keeps logic and converters in reset.
// - Crystal disable stops oscillator; clearing restarts it.
// - Audio enable turns on audio from input one.
// - Mode change applies on write, within 250 us.
// - Transmit audio plus inband adds 6 dB inband gain.
// - Listed registers stay writable during receive or transmit.
`default_nettype none
package pmc_pkg;
	localparam logic [7:0] ADDR_GENERAL_RESET = 8'h01;
	localparam logic [7:0] ADDR_POWER_DOWN = 8'hc0;
	localparam logic [7:0] ADDR_MODE = 8'hc1;
	localparam logic [7:0] ADDR_AUX_MOD = 8'ha7;
	localparam logic [7:0] ADDR_OUT_GAIN = 8'hb0;
	localparam logic [7:0] ADDR_IN_GAIN = 8'hb1;
	localparam logic [7:0] ADDR_TX_TONES = 8'hc3;
	localparam logic [7:0] ADDR_TX_DATA0 = 8'hca;
	localparam logic [7:0] ADDR_TX_DATA1 = 8'hcb;
	localparam logic [7:0] ADDR_AUDIO_TONE = 8'hcd;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'hce;

	localparam int PD_CORE_HOLD_BIT = 5;
	localparam int PD_XTAL_DIS_BIT = 3;
	localparam int PD_INPUT2_BIT = 2;
	localparam logic [15:0] PD_WRITE_MASK = 16'hfffc;
	localparam logic [15:0] PD_RESET = 16'h0000;

	localparam int MC_AUDIO_BIT = 14;
	localparam int MC_ALERT_SRC_BIT = 13;
	localparam int MC_ALERT_EN_BIT = 12;
	localparam int MC_INB_SRC_BIT = 11;
	localparam int MC_TONE_EN_BIT = 10;
	localparam int MC_PAIR_EN_BIT = 8;
	localparam int MC_MODEM_SRC_BIT = 4;
	localparam int MC_MODEM_EN_BIT = 2;
	localparam logic [15:0] MC_WRITE_MASK = 16'h7d17;
	localparam logic [15:0] MC_RESET = 16'h0000;

	localparam logic [1:0] MODE_IDLE = 2'h0;
	localparam logic [1:0] MODE_RX = 2'h1;
	localparam logic [1:0] MODE_TX = 2'h2;

	typedef enum {PMC_IDLE, PMC_RX, PMC_TX, PMC_UNUSED} pmc_mode_t;

	localparam int CLOCK_MHZ = 100;
	localparam int APPLY_LATENCY_US = 250;
	localparam int APPLY_LATENCY_CYCLES = APPLY_LATENCY_US * CLOCK_MHZ;

	function automatic pmc_mode_t pmc_decode_mode(input logic [1:0] code);
		pmc_decode_mode = (code == MODE_IDLE) ? PMC_IDLE :
			(code == MODE_RX) ? PMC_RX :
			(code == MODE_TX) ? PMC_TX : PMC_UNUSED;
	endfunction
endpackage
`default_nettype wire

// [design/pmc_mode_gate.sv]
/*
 Turns the stored mode word into registered function enables and source
 selects. Assumes the mode word and hold level come from flip-flops.
*/
`timescale 1ns/100ps
`default_nettype none
module pmc_mode_gate import pmc_pkg::*; (
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	input wire logic [15:0] modeWord,
	input wire logic coreHold,
	output logic rxActive,
	output logic txActive,
	output logic audioEnable,
	output logic watEnable,
	output logic sameEnable,
	output logic alertSource,
	output logic inbandSource,
	output logic toneGenEnable,
	output logic tonePairEnable,
	output logic modemSource,
	output logic modemEnable,
	output logic inbandBoost,
	output logic txConflict,
	output logic auxConvEnable
);
	pmc_mode_t modeSel;
	wire logic live;
	wire logic inbandOn;
	wire logic [11:0] enNext;
	logic [11:0] en_reg;

	assign modeSel = pmc_decode_mode(modeWord[1:0]);
	// A held core shows every function off, converters included.
	assign live = !coreHold;
	assign inbandOn = modeWord[MC_TONE_EN_BIT] | modeWord[MC_PAIR_EN_BIT];
	assign enNext[0] = live && modeSel == PMC_RX;
	assign enNext[1] = live && modeSel == PMC_TX;
	assign enNext[2] = live && modeWord[MC_AUDIO_BIT];
	assign enNext[3] = live && modeWord[MC_ALERT_EN_BIT];
	assign enNext[4] = modeWord[MC_ALERT_SRC_BIT];
	assign enNext[5] = modeWord[MC_INB_SRC_BIT];
	assign enNext[6] = live && modeWord[MC_TONE_EN_BIT];
	assign enNext[7] = live && modeWord[MC_PAIR_EN_BIT];
	assign enNext[8] = modeWord[MC_MODEM_SRC_BIT];
	assign enNext[9] = live && modeWord[MC_MODEM_EN_BIT];
	assign enNext[10] = enNext[1] && modeWord[MC_AUDIO_BIT] && inbandOn;
	// Flags a host breaking the one-function-at-a-time transmit limit.
	assign enNext[11] = enNext[1] && ((modeWord[MC_AUDIO_BIT] && inbandOn)
		|| (modeWord[MC_AUDIO_BIT] && modeWord[MC_MODEM_EN_BIT])
		|| (inbandOn && modeWord[MC_MODEM_EN_BIT]));

	always_ff @(posedge clock) begin
		if (srst)
			en_reg <= 12'h000;
		else if (ce)
			en_reg <= enNext;
	end

	assign rxActive = en_reg[0];
	assign txActive = en_reg[1];
	assign audioEnable = en_reg[2];
	assign watEnable = en_reg[3];
	assign sameEnable = en_reg[3];
	assign alertSource = en_reg[4];
	assign inbandSource = en_reg[5];
	assign toneGenEnable = en_reg[6];
	assign tonePairEnable = en_reg[7];
	assign modemSource = en_reg[8];
	assign modemEnable = en_reg[9];
	assign inbandBoost = en_reg[10];
	assign txConflict = en_reg[11];
	assign auxConvEnable = live;

	boost_a: assert property (@(posedge clock) disable iff (srst)
		ce && modeWord[1:0] == MODE_TX && modeWord[MC_AUDIO_BIT]
		&& modeWord[MC_TONE_EN_BIT] && !coreHold |=> inbandBoost)
		else $error("inband boost missing in transmit");
	mode_unused_a: assert property (@(posedge clock) disable iff (srst)
		ce && modeWord[1:0] == 2'h3 |=> !rxActive && !txActive)
		else $error("unused mode code activated a mode");
	alert_pair_a: assert property (@(posedge clock) disable iff (srst)
		watEnable == sameEnable)
		else $error("alert decoders enabled apart");
	source_follow_a: assert property (@(posedge clock) disable iff (srst)
		ce |=> modemSource == $past(modeWord[MC_MODEM_SRC_BIT])
		&& inbandSource == $past(modeWord[MC_INB_SRC_BIT]))
		else $error("source select did not follow mode word");
	boost_cover_c: cover property (@(posedge clock) inbandBoost);
endmodule
`default_nettype wire

// [design/pmc_power_and_mode_control.sv]
/*
 Power-down and mode control registers with halt, general reset escape
 and receive/transmit write filtering. Assumes the serial control bus
 interface delivers each decoded command as a one-cycle strobe with its
 address and data word, synchronous to the clock.
*/
`timescale 1ns/100ps
`default_nettype none
module pmc_power_and_mode_control import pmc_pkg::*; #(
	parameter int APPLY_LIMIT = APPLY_LATENCY_CYCLES
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	input wire logic cmdStrobe,
	input wire logic [7:0] cmdAddr,
	input wire logic [15:0] cmdData,
	output logic coreResetHold,
	output logic crystalStop,
	output logic input2Enable,
	output logic [15:0] powerWord,
	output logic [15:0] modeWord,
	output logic generalResetPulse,
	output logic fwdStrobe,
	output logic [7:0] fwdAddr,
	output logic [15:0] fwdData,
	output logic droppedPulse,
	output logic lockedPulse,
	output logic rxActive,
	output logic txActive,
	output logic audioEnable,
	output logic watEnable,
	output logic sameEnable,
	output logic alertSource,
	output logic inbandSource,
	output logic toneGenEnable,
	output logic tonePairEnable,
	output logic modemSource,
	output logic modemEnable,
	output logic inbandBoost,
	output logic txConflict,
	output logic auxConvEnable
);
	// Registers that stay writable while a receive or transmit session runs.
	function automatic logic session_writable(input logic [7:0] a);
		session_writable = a == ADDR_OUT_GAIN || a == ADDR_AUX_MOD
			|| a == ADDR_IN_GAIN || a == ADDR_POWER_DOWN
			|| a == ADDR_TX_TONES || a == ADDR_TX_DATA0
			|| a == ADDR_TX_DATA1 || a == ADDR_AUDIO_TONE
			|| a == ADDR_IRQ_MASK || a == ADDR_MODE;
	endfunction

	logic [15:0] power_reg;
	logic [15:0] power_next;
	logic [15:0] mode_reg;
	logic [15:0] mode_next;
	logic genReset_reg;
	logic fwd_reg;
	logic [7:0] fwdAddr_reg;
	logic [15:0] fwdData_reg;
	logic dropped_reg;
	logic locked_reg;

	wire logic halted;
	wire logic take;
	wire logic genReset;
	wire logic accepted;
	wire logic inSession;
	wire logic ownReg;
	wire logic allowed;
	wire logic powerWrite;
	wire logic modeWrite;
	wire logic fwdNext;

	// Core hold or crystal disable stops command handling, general reset excepted.
	assign halted = power_reg[PD_CORE_HOLD_BIT]
		| power_reg[PD_XTAL_DIS_BIT];
	assign take = ce && cmdStrobe;
	assign genReset = take && cmdAddr == ADDR_GENERAL_RESET;
	assign accepted = take && !halted && !genReset;
	assign inSession = mode_reg[1:0] == MODE_RX
		|| mode_reg[1:0] == MODE_TX;
	assign ownReg = cmdAddr == ADDR_POWER_DOWN || cmdAddr == ADDR_MODE;
	// Setup registers are frozen in a session, so late writes are refused.
	assign allowed = !inSession || session_writable(cmdAddr);
	assign powerWrite = accepted && cmdAddr == ADDR_POWER_DOWN;
	assign modeWrite = accepted && cmdAddr == ADDR_MODE;
	assign fwdNext = accepted && !ownReg && allowed;
	// Reserved low power bits are kept clear whatever the host sends.
	assign power_next = genReset ? PD_RESET :
		powerWrite ? (cmdData & PD_WRITE_MASK) : power_reg;
	assign mode_next = genReset ? MC_RESET :
		modeWrite ? (cmdData & MC_WRITE_MASK) : mode_reg;

	always_ff @(posedge clock) begin
		if (srst) begin
			power_reg <= PD_RESET;
			mode_reg <= MC_RESET;
		end else if (ce) begin
			power_reg <= power_next;
			mode_reg <= mode_next;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			genReset_reg <= 1'b0;
			fwd_reg <= 1'b0;
			dropped_reg <= 1'b0;
			locked_reg <= 1'b0;
		end else if (ce) begin
			genReset_reg <= genReset;
			fwd_reg <= fwdNext;
			dropped_reg <= take && halted && !genReset;
			locked_reg <= accepted && !ownReg && !allowed;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			fwdAddr_reg <= 8'h00;
			fwdData_reg <= 16'h0000;
		end else if (ce && fwdNext) begin
			fwdAddr_reg <= cmdAddr;
			fwdData_reg <= cmdData;
		end
	end

	// The oscillator itself lives outside; this level stops and restarts
	// it. The host must allow settling time after a restart.
	assign crystalStop = power_reg[PD_XTAL_DIS_BIT];
	assign coreResetHold = power_reg[PD_CORE_HOLD_BIT];
	assign input2Enable = power_reg[PD_INPUT2_BIT];
	assign powerWord = power_reg;
	assign modeWord = mode_reg;
	assign generalResetPulse = genReset_reg;
	assign fwdStrobe = fwd_reg;
	assign fwdAddr = fwdAddr_reg;
	assign fwdData = fwdData_reg;
	assign droppedPulse = dropped_reg;
	assign lockedPulse = locked_reg;

	pmc_mode_gate gate (
		.clock(clock),
		.srst(srst),
		.ce(ce),
		.modeWord(mode_reg),
		.coreHold(power_reg[PD_CORE_HOLD_BIT]),
		.rxActive(rxActive),
		.txActive(txActive),
		.audioEnable(audioEnable),
		.watEnable(watEnable),
		.sameEnable(sameEnable),
		.alertSource(alertSource),
		.inbandSource(inbandSource),
		.toneGenEnable(toneGenEnable),
		.tonePairEnable(tonePairEnable),
		.modemSource(modemSource),
		.modemEnable(modemEnable),
		.inbandBoost(inbandBoost),
		.txConflict(txConflict),
		.auxConvEnable(auxConvEnable)
	);

	// Cycles since the last mode write; holds at all ones rather than wrapping.
	logic [31:0] applyCount;
	always_ff @(posedge clock) begin
		if (srst || modeWrite)
			applyCount <= 32'h0;
		else if (applyCount != 32'hffffffff)
			applyCount <= applyCount + 32'h1;
	end

	power_on_a: assert property (@(posedge clock)
		srst |=> !coreResetHold && !crystalStop)
		else $error("power bits not clear after reset");
	halt_ignore_a: assert property (@(posedge clock) disable iff (srst)
		halted && take && cmdAddr != ADDR_GENERAL_RESET
		|=> !fwdStrobe && droppedPulse && $stable(mode_reg))
		else $error("command acted on while halted");
	reset_escape_a: assert property (@(posedge clock) disable iff (srst)
		genReset |=> !coreResetHold && !crystalStop
		&& mode_reg == MC_RESET && generalResetPulse)
		else $error("general reset did not release halt");
	hold_gates_a: assert property (@(posedge clock) disable iff (srst)
		ce && coreResetHold && !genReset |=> !auxConvEnable && !audioEnable
		&& !rxActive && !txActive)
		else $error("processing active under core hold");
	crystal_stop_a: assert property (@(posedge clock) disable iff (srst)
		powerWrite |=> crystalStop == $past(cmdData[PD_XTAL_DIS_BIT]))
		else $error("crystal stop not following write");
	audio_apply_a: assert property (@(posedge clock) disable iff (srst)
		modeWrite && cmdData[MC_AUDIO_BIT]
		##1 ce && !coreResetHold
		|=> audioEnable)
		else $error("audio enable did not apply");
	apply_bound_a: assert property (@(posedge clock) disable iff (srst)
		ce && applyCount == 32'h1 && !coreResetHold
		|=> txActive == ($past(mode_reg[1:0]) == MODE_TX)
		&& applyCount < APPLY_LIMIT)
		else $error("mode change not applied in time");
	session_lock_a: assert property (@(posedge clock) disable iff (srst)
		accepted && inSession && !ownReg |=> fwdStrobe
		== session_writable($past(cmdAddr)) && lockedPulse == !fwdStrobe)
		else $error("session write filter wrong");
	// Only the general reset may move the stored words out of a halt.
	halt_freeze_a: assert property (@(posedge clock) disable iff (srst)
		ce && halted && !genReset
		|=> $stable(power_reg) && $stable(mode_reg) && !fwdStrobe)
		else $error("halted state changed without general reset");
	mode_store_a: assert property (@(posedge clock) disable iff (srst)
		modeWrite |=> modeWord == ($past(cmdData) & MC_WRITE_MASK))
		else $error("mode word not stored on write");
	fwd_copy_a: assert property (@(posedge clock) disable iff (srst)
		fwdNext |=> fwdStrobe && fwdAddr == $past(cmdAddr)
		&& fwdData == $past(cmdData))
		else $error("forwarded write lost address or data");
	halt_cover_c: cover property (@(posedge clock) disable iff (srst)
		halted && take && !genReset);
	escape_cover_c: cover property (@(posedge clock) disable iff (srst)
		halted ##1 genReset);
	locked_cover_c: cover property (@(posedge clock) lockedPulse);
	tx_cover_c: cover property (@(posedge clock) txActive && txConflict);
endmodule
`default_nettype wire

// [test/pmc_host_model.sv]
/*
 Host controller model that sends decoded control-bus commands, one per
 clock at most, from a queue filled by the bench.
 Assumes the bench pushes {address, data} words and never drives the port.
*/
`timescale 1ns/100ps
`default_nettype none
module pmc_host_model import pmc_pkg::*; #(
	parameter int SETTLE = 8
) (
	input wire logic clock,
	output logic cmdStrobe,
	output logic [7:0] cmdAddr,
	output logic [15:0] cmdData
);
	logic [23:0] q[$];
	logic [23:0] c;
	logic go;
	logic xtalOff = 1'b0;
	int gap = 0;
	initial begin
		cmdStrobe = 1'b0;
		cmdAddr = 8'h00;
		cmdData = 16'h0000;
	end
	always @(posedge clock) begin
		go = gap == 0 && q.size() > 0;
		c = go ? q.pop_front() : 24'h000000;
		if (gap > 0)
			gap--;
		cmdStrobe <= go;
		if (go) begin
			cmdAddr <= c[23:16];
			// Reserved low power bits always go out as zero.
			cmdData <= (c[23:16] == ADDR_POWER_DOWN) ?
				c[15:0] & 16'hfffc : c[15:0];
			if (c[23:16] == ADDR_POWER_DOWN
				|| c[23:16] == ADDR_GENERAL_RESET) begin
				// A restarted oscillator needs time before more traffic.
				if (xtalOff && !(c[23:16] == ADDR_POWER_DOWN && c[3]))
					gap = SETTLE;
				xtalOff = c[23:16] == ADDR_POWER_DOWN && c[3];
			end
		end
	end
endmodule
`default_nettype wire

// [test/tb.sv]
/*
 Self-checking bench for the power and mode control registers.
 Assumes the host model in pmc_host_model and a 100 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb import pmc_pkg::*; ;
	typedef struct {
		logic [15:0] pw, mw, fd;
		logic [7:0] fa;
		logic [3:0] pl;
		logic [12:0] en;
	} pmc_note_t;
	logic clock, srst, ce, cmdStrobe;
	logic [7:0] cmdAddr, fwdAddr, a, fa;
	logic [15:0] cmdData, powerWord, modeWord, fwdData, pw, mw, fd;
	logic coreResetHold, crystalStop, input2Enable, generalResetPulse;
	logic fwdStrobe, droppedPulse, lockedPulse, rxActive, txActive;
	logic audioEnable, watEnable, sameEnable, alertSource, inbandSource;
	logic toneGenEnable, tonePairEnable, modemSource, modemEnable;
	logic inbandBoost, txConflict, auxConvEnable, v1, v2;
	logic [12:0] enSeen;
	logic [31:0] seed = 32'h0000925e;
	logic [31:0] r;
	logic [7:0] adr[9] = '{ADDR_AUX_MOD, ADDR_OUT_GAIN, ADDR_IN_GAIN,
		ADDR_TX_TONES, ADDR_TX_DATA0, ADDR_TX_DATA1, ADDR_AUDIO_TONE,
		ADDR_IRQ_MASK, 8'hc2};
	pmc_note_t notes[$];
	pmc_note_t n1, n2;
	int miscompares = 0;
	int n_compared = 0;
	assign enSeen = {rxActive, txActive, audioEnable, watEnable, sameEnable,
		alertSource, inbandSource, toneGenEnable, tonePairEnable, modemSource,
		modemEnable, inbandBoost, txConflict};
	pmc_power_and_mode_control #(.APPLY_LIMIT(30)) dut (.clock, .srst, .ce,
		.cmdStrobe, .cmdAddr, .cmdData, .coreResetHold, .crystalStop,
		.input2Enable, .powerWord, .modeWord, .generalResetPulse, .fwdStrobe,
		.fwdAddr, .fwdData, .droppedPulse, .lockedPulse, .rxActive, .txActive,
		.audioEnable, .watEnable, .sameEnable, .alertSource, .inbandSource,
		.toneGenEnable, .tonePairEnable, .modemSource, .modemEnable,
		.inbandBoost, .txConflict, .auxConvEnable);
	pmc_host_model host (.clock, .cmdStrobe, .cmdAddr, .cmdData);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [12:0] en_of(input logic [15:0] p, m);
		logic on, tx, inb;
		on = !p[5];
		tx = on && m[1:0] == MODE_TX;
		inb = m[10] | m[8];
		return {on && m[1:0] == MODE_RX, tx, on && m[14], {2{on && m[12]}},
			m[13], m[11], on && m[10], on && m[8], m[4], on && m[2],
			tx && m[14] && inb,
			tx && (2'(m[14]) + 2'(inb) + 2'(m[2]) > 2'd1)};
	endfunction
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cmd(input logic [7:0] ad, input logic [15:0] d);
		pmc_note_t n;
		logic act;
		act = mw[1:0] == MODE_RX || mw[1:0] == MODE_TX;
		n.pl = 4'h0;
		if ((pw[5] | pw[3]) && ad != ADDR_GENERAL_RESET)
			n.pl = 4'h2;
		else if (ad == ADDR_GENERAL_RESET) begin
			pw = PD_RESET;
			mw = MC_RESET;
			n.pl = 4'h8;
		end else if (ad == ADDR_POWER_DOWN)
			pw = d & PD_WRITE_MASK;
		else if (ad == ADDR_MODE)
			mw = d & MC_WRITE_MASK;
		else if (act && ad == 8'hc2)
			n.pl = 4'h1;
		else begin
			n.pl = 4'h4;
			fa = ad;
			fd = d;
		end
		n.pw = pw;
		n.mw = mw;
		n.fa = fa;
		n.fd = fd;
		n.en = en_of(pw, mw);
		notes.push_back(n);
		host.q.push_back({ad, d});
	endtask
	task automatic drain(input string nm);
		while (notes.size() > 0)
			@(negedge clock);
		repeat (3) @(negedge clock);
		$display("test %s done", nm);
	endtask
	task automatic conclude();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(negedge clock) begin
		if (srst) begin
			v1 = 1'b0;
			v2 = 1'b0;
		end else begin
			if (v2)
				chk("en", 32'(enSeen), 32'(n2.en));
			if (v1) begin
				chk("powerWord", 32'(powerWord), 32'(n1.pw));
				chk("modeWord", 32'(modeWord), 32'(n1.mw));
				chk("pulses", 32'({generalResetPulse, fwdStrobe, droppedPulse,
					lockedPulse}), 32'(n1.pl));
				chk("forward", 32'({fwdAddr, fwdData}),
					32'({n1.fa, n1.fd}));
				chk("levels", 32'({coreResetHold, crystalStop, input2Enable,
					auxConvEnable}), 32'({n1.pw[5], n1.pw[3], n1.pw[2],
					!n1.pw[5]}));
			end
			v2 = v1;
			n2 = n1;
			v1 = cmdStrobe;
			if (v1)
				n1 = notes.pop_front();
		end
	end
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		conclude();
	end
	initial begin
		srst = 1'b1;
		ce = 1'b1;
		pw = 16'h0000;
		mw = 16'h0000;
		fa = 8'h00;
		fd = 16'h0000;
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		@(negedge clock);
		chk("resetWords", {powerWord, modeWord}, 32'h0);
		chk("resetEnables", 32'(enSeen), 32'h0);
		chk("resetAux", 32'(auxConvEnable), 32'h1);
		drain("reset");
		for (int i = 0; i < 24; i++) begin
			r = rnd();
			cmd(ADDR_MODE, {r[15:2], 2'(i)});
		end
		cmd(ADDR_MODE, 16'h4502);
		cmd(ADDR_MODE, 16'h4002);
		drain("modes");
		for (int m = 1; m < 3; m++) begin
			cmd(ADDR_MODE, 16'(m));
			foreach (adr[k])
				cmd(adr[k], 16'(rnd()));
		end
		cmd(ADDR_MODE, 16'h0003);
		cmd(8'hc2, 16'h1234);
		drain("locking");
		for (int k = 0; k < 2; k++) begin
			cmd(ADDR_MODE, 16'h5006);
			cmd(ADDR_POWER_DOWN, k ? 16'h0024 : 16'h000c);
			cmd(ADDR_MODE, 16'h0001);
			cmd(ADDR_POWER_DOWN, 16'h0000);
			cmd(ADDR_OUT_GAIN, 16'h00ff);
			cmd(ADDR_GENERAL_RESET, 16'h0000);
			cmd(ADDR_POWER_DOWN, 16'h0004);
		end
		drain("halt");
		for (int i = 0; i < 60; i++) begin
			r = rnd();
			a = r[18:16] == 3'h0 ? ADDR_MODE : adr[r[22:19] % 9];
			if (r[26:23] == 4'h0)
				a = r[27] ? ADDR_GENERAL_RESET : ADDR_POWER_DOWN;
			cmd(a, r[15:0]);
		end
		cmd(ADDR_GENERAL_RESET, 16'h0000);
		drain("burst");
		// A command offered while the clock enable is low must change nothing.
		@(posedge clock);
		ce <= 1'b0;
		@(negedge clock);
		notes.push_back(pmc_note_t'{pw, mw, fd, fa, 4'h0, en_of(pw, mw)});
		host.q.push_back({ADDR_MODE, 16'h4002});
		drain("frozen");
		@(posedge clock);
		ce <= 1'b1;
		cmd(ADDR_MODE, 16'h4002);
		drain("thaw");
		conclude();
	end
endmodule
`default_nettype wire
